// File: usb_sched_pkg.sv
package usb_sched_pkg;

   // On-chip SRAM: 8 kbyte, byte addressed
   localparam int SRAM_BYTES = 8192;
   localparam int ADDR_W     = $clog2(SRAM_BYTES);

   // Frame timing
   localparam int FRAME_TIME_US = 1000;
   localparam int CLK_FREQ_KHZ  = 25000;
   localparam int FRAME_CYCLES  = FRAME_TIME_US * CLK_FREQ_KHZ / 1000;
   localparam int FRAME_CNT_W   = 16;
   localparam int PER_SLOTS     = 32;
   localparam int SLOT_W        = $clog2(PER_SLOTS);

   // Endpoint descriptor: 16 bytes, 16-byte aligned
   localparam int DESC_ALIGN_W = 4;
   localparam logic [ADDR_W-1:0] ED_OFS_CTRL = 13'h0000;
   localparam logic [ADDR_W-1:0] ED_OFS_TAIL = 13'h0004;
   localparam logic [ADDR_W-1:0] ED_OFS_HEAD = 13'h0008;
   localparam logic [ADDR_W-1:0] ED_OFS_NEXT = 13'h000C;
   localparam logic [ADDR_W-1:0] TD_OFS_NEXT = 13'h0008;

   // Communications area offsets
   localparam logic [ADDR_W-1:0] HCCA_OFS_DONE = 13'h0084;

   // Endpoint control word fields
   localparam int ED_FA_LSB  = 0;
   localparam int ED_FA_W    = 7;
   localparam int ED_EN_LSB  = 7;
   localparam int ED_EN_W    = 4;
   localparam int ED_DIR_LSB = 11;
   localparam int ED_DIR_W   = 2;
   localparam int ED_SPD_BIT = 13;
   localparam int ED_SKP_BIT = 14;
   localparam int ED_FMT_BIT = 15;
   localparam int ED_MPS_LSB = 16;
   localparam int ED_MPS_W   = 11;

   // Head pointer flag bits
   localparam int HEAD_HALT_BIT  = 0;
   localparam int HEAD_CARRY_BIT = 1;

   typedef enum logic [1:0] {
      PH_PERIODIC,
      PH_CONTROL,
      PH_BULK
   } phase_type;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_RD_PER_HEAD,
      ST_WALK,
      ST_RD_ED_CTRL,
      ST_RD_ED_TAIL,
      ST_RD_ED_HEAD,
      ST_RD_ED_NEXT,
      ST_CHECK,
      ST_RD_TD_NEXT,
      ST_XFER,
      ST_WR_ED_HEAD,
      ST_WR_TD_LINK,
      ST_WR_DONE_HEAD,
      ST_NEXT_LIST
   } state_type;

endpackage : usb_sched_pkg

// File: usb_host_list_scheduler.sv
`timescale 1ns/1ps

module usb_host_list_scheduler #(
   parameter int FRAME_CYCLES = usb_sched_pkg::FRAME_CYCLES
) (
   // Clock and reset
   input  wire logic                               clk_i,
   input  wire logic                               rst_b_i,
   // List control
   input  wire logic                               run_i,
   input  wire logic                               per_enable_i,
   input  wire logic                               ctrl_enable_i,
   input  wire logic                               bulk_enable_i,
   input  wire logic [usb_sched_pkg::ADDR_W-1:0]   ctrl_head_i,
   input  wire logic [usb_sched_pkg::ADDR_W-1:0]   bulk_head_i,
   input  wire logic [usb_sched_pkg::ADDR_W-1:0]   hcca_base_i,
   // SRAM port
   output logic                                    mem_req_o,
   output logic                                    mem_we_o,
   output logic [usb_sched_pkg::ADDR_W-1:0]        mem_addr_o,
   output logic [31:0]                             mem_wdata_o,
   input  wire logic [31:0]                        mem_rdata_i,
   input  wire logic                               mem_ack_i,
   // Packet engine
   output logic                                    td_start_o,
   output logic [usb_sched_pkg::ADDR_W-1:0]        td_addr_o,
   output logic [usb_sched_pkg::ED_FA_W-1:0]       td_func_addr_o,
   output logic [usb_sched_pkg::ED_EN_W-1:0]       td_endpoint_o,
   output logic [usb_sched_pkg::ED_DIR_W-1:0]      td_dir_o,
   output logic                                    td_low_speed_o,
   output logic                                    td_iso_o,
   output logic [usb_sched_pkg::ED_MPS_W-1:0]      td_max_packet_o,
   input  wire logic                               td_done_i,
   input  wire logic                               td_halt_i,
   // Status
   output logic [usb_sched_pkg::FRAME_CNT_W-1:0]   frame_num_o,
   output logic [usb_sched_pkg::ADDR_W-1:0]        done_head_o
);

   localparam int AW = usb_sched_pkg::ADDR_W;
   localparam int DW = usb_sched_pkg::DESC_ALIGN_W;
   localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);

   usb_sched_pkg::state_type state_q, state_d;
   usb_sched_pkg::phase_type phase_q, phase_d;

   logic [15:0]                          div_q, div_d;
   logic [usb_sched_pkg::FRAME_CNT_W-1:0] frame_q, frame_d;
   logic                                 pend_q, pend_d;
   logic [AW-1:0]                        ed_q, ed_d;
   logic [AW-1:0]                        next_ed_q, next_ed_d;
   logic [31:0]                          ed_ctrl_q, ed_ctrl_d;
   logic [31:0]                          tail_q, tail_d;
   logic [31:0]                          head_q, head_d;
   logic [31:0]                          td_next_q, td_next_d;
   logic                                 halt_q, halt_d;
   logic [AW-1:0]                        done_q, done_d;
   logic                                 mem_req_q, mem_req_d;
   logic                                 mem_we_q, mem_we_d;
   logic [AW-1:0]                        mem_addr_q, mem_addr_d;
   logic [31:0]                          mem_wdata_q, mem_wdata_d;
   logic                                 td_start_q, td_start_d;
   logic                                 mem_state;
   logic [AW-1:0]                        head_ptr;

   function automatic logic [AW-1:0] align(input logic [31:0] p);
      align = {p[AW-1:DW], {DW{1'b0}}};
   endfunction : align

   // Head descriptor address, flag bits stripped
   assign head_ptr = align(head_q);

   always_comb
   begin
      state_d     = state_q;
      phase_d     = phase_q;
      div_d       = div_q;
      frame_d     = frame_q;
      pend_d      = pend_q;
      ed_d        = ed_q;
      next_ed_d   = next_ed_q;
      ed_ctrl_d   = ed_ctrl_q;
      tail_d      = tail_q;
      head_d      = head_q;
      td_next_d   = td_next_q;
      halt_d      = halt_q;
      done_d      = done_q;
      mem_we_d    = 1'b0;
      mem_addr_d  = mem_addr_q;
      mem_wdata_d = mem_wdata_q;
      td_start_d  = 1'b0;
      mem_state   = 1'b0;

      // 1 ms frame divider and frame counter
      if (run_i)
      begin
         if (div_q == FRAME_LAST)
         begin
            div_d   = '0;
            frame_d = frame_q + 1'b1;
            pend_d  = 1'b1;
         end
         else
         begin
            div_d = div_q + 16'h0001;
         end
      end

      unique case (state_q)
         usb_sched_pkg::ST_IDLE:
         begin
            if (pend_q && run_i)
            begin
               pend_d  = 1'b0;
               phase_d = usb_sched_pkg::PH_PERIODIC;
               if (per_enable_i)
                  state_d = usb_sched_pkg::ST_RD_PER_HEAD;
               else
                  state_d = usb_sched_pkg::ST_NEXT_LIST;
            end
         end
         usb_sched_pkg::ST_RD_PER_HEAD:
         begin
            mem_state  = 1'b1;
            // Slot chosen by the low frame bits, each slot one word
            mem_addr_d = hcca_base_i
                       + AW'({frame_q[usb_sched_pkg::SLOT_W-1:0], 2'b00});
            if (mem_ack_i)
            begin
               ed_d    = align(mem_rdata_i);
               state_d = usb_sched_pkg::ST_WALK;
            end
         end
         usb_sched_pkg::ST_WALK:
         begin
            // Periodic walk just follows links, so isochronous EDs after the 1 ms node are seen
            if (ed_q == '0)
               state_d = usb_sched_pkg::ST_NEXT_LIST;
            else if (pend_q && phase_q != usb_sched_pkg::PH_PERIODIC)
               state_d = usb_sched_pkg::ST_IDLE;
            else
               state_d = usb_sched_pkg::ST_RD_ED_CTRL;
         end
         usb_sched_pkg::ST_RD_ED_CTRL:
         begin
            mem_state  = 1'b1;
            mem_addr_d = ed_q + usb_sched_pkg::ED_OFS_CTRL;
            if (mem_ack_i)
            begin
               ed_ctrl_d = mem_rdata_i;
               state_d   = usb_sched_pkg::ST_RD_ED_TAIL;
            end
         end
         usb_sched_pkg::ST_RD_ED_TAIL:
         begin
            mem_state  = 1'b1;
            mem_addr_d = ed_q + usb_sched_pkg::ED_OFS_TAIL;
            if (mem_ack_i)
            begin
               tail_d  = mem_rdata_i;
               state_d = usb_sched_pkg::ST_RD_ED_HEAD;
            end
         end
         usb_sched_pkg::ST_RD_ED_HEAD:
         begin
            mem_state  = 1'b1;
            mem_addr_d = ed_q + usb_sched_pkg::ED_OFS_HEAD;
            if (mem_ack_i)
            begin
               head_d  = mem_rdata_i;
               state_d = usb_sched_pkg::ST_RD_ED_NEXT;
            end
         end
         usb_sched_pkg::ST_RD_ED_NEXT:
         begin
            mem_state  = 1'b1;
            mem_addr_d = ed_q + usb_sched_pkg::ED_OFS_NEXT;
            if (mem_ack_i)
            begin
               next_ed_d = align(mem_rdata_i);
               state_d   = usb_sched_pkg::ST_CHECK;
            end
         end
         usb_sched_pkg::ST_CHECK:
         begin
            if (ed_ctrl_q[usb_sched_pkg::ED_SKP_BIT] || head_q[usb_sched_pkg::HEAD_HALT_BIT]
                || align(tail_q) == head_ptr)
            begin
               ed_d    = next_ed_q;
               state_d = usb_sched_pkg::ST_WALK;
            end
            else
            begin
               state_d = usb_sched_pkg::ST_RD_TD_NEXT;
            end
         end
         usb_sched_pkg::ST_RD_TD_NEXT:
         begin
            mem_state  = 1'b1;
            mem_addr_d = head_ptr + usb_sched_pkg::TD_OFS_NEXT;
            if (mem_ack_i)
            begin
               td_next_d  = mem_rdata_i;
               td_start_d = 1'b1;
               state_d    = usb_sched_pkg::ST_XFER;
            end
         end
         usb_sched_pkg::ST_XFER:
         begin
            if (td_done_i)
            begin
               halt_d  = td_halt_i;
               state_d = usb_sched_pkg::ST_WR_ED_HEAD;
            end
         end
         usb_sched_pkg::ST_WR_ED_HEAD:
         begin
            mem_state   = 1'b1;
            mem_we_d    = 1'b1;
            mem_addr_d  = ed_q + usb_sched_pkg::ED_OFS_HEAD;
            // Link of the finished TD becomes the new queue head, carry kept
            mem_wdata_d = {td_next_q[31:DW], 2'b00,
                           head_q[usb_sched_pkg::HEAD_CARRY_BIT], halt_q};
            if (mem_ack_i)
               state_d = usb_sched_pkg::ST_WR_TD_LINK;
         end
         usb_sched_pkg::ST_WR_TD_LINK:
         begin
            mem_state   = 1'b1;
            mem_we_d    = 1'b1;
            mem_addr_d  = head_ptr + usb_sched_pkg::TD_OFS_NEXT;
            mem_wdata_d = 32'(done_q);
            if (mem_ack_i)
            begin
               done_d  = head_ptr;
               state_d = usb_sched_pkg::ST_WR_DONE_HEAD;
            end
         end
         usb_sched_pkg::ST_WR_DONE_HEAD:
         begin
            mem_state   = 1'b1;
            mem_we_d    = 1'b1;
            mem_addr_d  = hcca_base_i + usb_sched_pkg::HCCA_OFS_DONE;
            mem_wdata_d = 32'(done_q);
            if (mem_ack_i)
            begin
               ed_d    = next_ed_q;
               state_d = usb_sched_pkg::ST_WALK;
            end
         end
         usb_sched_pkg::ST_NEXT_LIST:
         begin
            unique case (phase_q)
               usb_sched_pkg::PH_PERIODIC:
               begin
                  phase_d = usb_sched_pkg::PH_CONTROL;
                  ed_d    = ctrl_enable_i ? align(32'(ctrl_head_i)) : '0;
                  state_d = usb_sched_pkg::ST_WALK;
               end
               usb_sched_pkg::PH_CONTROL:
               begin
                  phase_d = usb_sched_pkg::PH_BULK;
                  ed_d    = bulk_enable_i ? align(32'(bulk_head_i)) : '0;
                  state_d = usb_sched_pkg::ST_WALK;
               end
               default:
               begin
                  state_d = usb_sched_pkg::ST_IDLE;
               end
            endcase
         end
      endcase

      // Request held until acknowledged, dropped the cycle after the ack
      mem_req_d = mem_state && !mem_ack_i;
      if (!mem_state)
         mem_we_d = 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         state_q     <= usb_sched_pkg::ST_IDLE;
         phase_q     <= usb_sched_pkg::PH_PERIODIC;
         div_q       <= '0;
         frame_q     <= '0;
         pend_q      <= 1'b0;
         ed_q        <= '0;
         next_ed_q   <= '0;
         ed_ctrl_q   <= '0;
         tail_q      <= '0;
         head_q      <= '0;
         td_next_q   <= '0;
         halt_q      <= 1'b0;
         done_q      <= '0;
         mem_req_q   <= 1'b0;
         mem_we_q    <= 1'b0;
         mem_addr_q  <= '0;
         mem_wdata_q <= '0;
         td_start_q  <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         phase_q     <= phase_d;
         div_q       <= div_d;
         frame_q     <= frame_d;
         pend_q      <= pend_d;
         ed_q        <= ed_d;
         next_ed_q   <= next_ed_d;
         ed_ctrl_q   <= ed_ctrl_d;
         tail_q      <= tail_d;
         head_q      <= head_d;
         td_next_q   <= td_next_d;
         halt_q      <= halt_d;
         done_q      <= done_d;
         mem_req_q   <= mem_req_d;
         mem_we_q    <= mem_we_d;
         mem_addr_q  <= mem_addr_d;
         mem_wdata_q <= mem_wdata_d;
         td_start_q  <= td_start_d;
      end
   end

   assign mem_req_o       = mem_req_q;
   assign mem_we_o        = mem_we_q;
   assign mem_addr_o      = mem_addr_q;
   assign mem_wdata_o     = mem_wdata_q;
   assign td_start_o      = td_start_q;
   assign td_addr_o       = head_ptr;
   assign td_func_addr_o  = ed_ctrl_q[usb_sched_pkg::ED_FA_LSB +: usb_sched_pkg::ED_FA_W];
   assign td_endpoint_o   = ed_ctrl_q[usb_sched_pkg::ED_EN_LSB +: usb_sched_pkg::ED_EN_W];
   assign td_dir_o        = ed_ctrl_q[usb_sched_pkg::ED_DIR_LSB +: usb_sched_pkg::ED_DIR_W];
   assign td_low_speed_o  = ed_ctrl_q[usb_sched_pkg::ED_SPD_BIT];
   assign td_iso_o        = ed_ctrl_q[usb_sched_pkg::ED_FMT_BIT];
   assign td_max_packet_o = ed_ctrl_q[usb_sched_pkg::ED_MPS_LSB +: usb_sched_pkg::ED_MPS_W];
   assign frame_num_o     = frame_q;
   assign done_head_o     = done_q;

endmodule : usb_host_list_scheduler

// File: usb_sched_monitor.sv
`timescale 1ns/1ps

module usb_sched_monitor #(
   parameter int FRAME_CYCLES = 200
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // Setup
   input  wire logic [12:0]  hcca_base_i,
   // SRAM port
   input  wire logic         mem_req_o,
   input  wire logic         mem_we_o,
   input  wire logic [12:0]  mem_addr_o,
   input  wire logic [31:0]  mem_wdata_o,
   input  wire logic         mem_ack_i,
   // Packet engine and status
   input  wire logic         td_start_o,
   input  wire logic [12:0]  td_addr_o,
   input  wire logic [6:0]   td_func_addr_o,
   input  wire logic         td_done_i,
   input  wire logic         td_halt_i,
   input  wire logic [15:0]  frame_num_o,
   input  wire logic [12:0]  done_head_o
);
   logic [15:0] fr_q;
   logic [31:0] cnt_q;
   logic        seen_q;
   logic        busy_q;
   logic        done_wr;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   assign done_wr = mem_req_o && mem_we_o && mem_addr_o == hcca_base_i + 13'h0084;

   // Cycles between frame steps, and transfer in flight
   always_ff @(posedge clk_i)
   begin
      fr_q   <= frame_num_o;
      cnt_q  <= (frame_num_o != fr_q) ? 32'h1 : cnt_q + 32'h1;
      seen_q <= rst_b_i && (seen_q || frame_num_o != fr_q);
      busy_q <= rst_b_i && (td_start_o || (busy_q && !td_done_i));
   end

   chk_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
      && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
      else $error("memory request changed before ack");
   chk_req_gap: assert property (mem_ack_i |=> !mem_req_o)
      else $error("no idle cycle after ack");
   chk_word_align: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
      else $error("unaligned memory address");
   chk_frame_rate: assert property (seen_q && frame_num_o != fr_q |->
      frame_num_o == fr_q + 16'h1 && cnt_q == FRAME_CYCLES)
      else $error("frame step wrong");
   chk_slot_pick: assert property ($rose(mem_req_o) && !mem_we_o
      && mem_addr_o >= hcca_base_i && mem_addr_o < hcca_base_i + 13'h0080
      |-> mem_addr_o == hcca_base_i + {6'h00, frame_num_o[4:0], 2'h0})
      else $error("wrong periodic slot read");
   chk_done_link: assert property (done_wr |-> mem_wdata_o[12:0] == td_addr_o)
      else $error("done head write wrong");
   chk_done_out: assert property (done_wr && mem_ack_i |-> ##[0:2] done_head_o == td_addr_o)
      else $error("done head output wrong");
   chk_start_pulse: assert property (td_start_o |=> !td_start_o)
      else $error("start longer than one cycle");
   chk_one_td: assert property (busy_q |-> !td_start_o && $stable(td_addr_o)
      && $stable(td_func_addr_o))
      else $error("transfer overlapped or fields moved");
   chk_start_source: assert property (td_start_o |-> $past(mem_ack_i)
      && !$past(mem_we_o) && $past(mem_addr_o) == td_addr_o + 13'h0008)
      else $error("start without link read");

   cov_start: cover property (td_start_o);
   cov_halt: cover property (td_done_i && td_halt_i);
   cov_done: cover property (done_wr && mem_ack_i);
   cov_frame: cover property (seen_q && frame_num_o != fr_q);
endmodule : usb_sched_monitor

bind usb_host_list_scheduler usb_sched_monitor #(.FRAME_CYCLES(FRAME_CYCLES)) i_mon (
   .clk_i, .rst_b_i, .hcca_base_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
   .mem_ack_i, .td_start_o, .td_addr_o, .td_func_addr_o, .td_done_i, .td_halt_i,
   .frame_num_o, .done_head_o);

// File: usb_sched_partner.sv
`timescale 1ns/1ps

module usb_sched_partner (
   // Clock
   input  wire logic         clk_i,
   // SRAM side
   input  wire logic         mem_req_i,
   input  wire logic         mem_we_i,
   input  wire logic [12:0]  mem_addr_i,
   input  wire logic [31:0]  mem_wdata_i,
   output logic [31:0]       mem_rdata_o,
   output logic              mem_ack_o,
   // Packet engine side
   input  wire logic         td_start_i,
   input  wire logic [12:0]  td_addr_i,
   input  wire logic [12:0]  halt_addr_i,
   output logic              td_done_o,
   output logic              td_halt_o
);
   logic [31:0] mem [0:2047];
   logic [31:0] rd_q;
   logic [1:0]  wait_q;
   logic [2:0]  eng_q;
   logic        busy_q;

   initial
   begin
      for (int i = 0; i < 2048; i++)
         mem[i] = 32'h0;
      mem_ack_o = 1'b0;
      td_done_o = 1'b0;
      td_halt_o = 1'b0;
      rd_q = 32'h0;
      wait_q = 2'h0;
      eng_q = 3'h0;
      busy_q = 1'b0;
   end

   // Word memory with a random ack delay
   always @(posedge clk_i)
   begin
      mem_ack_o <= 1'b0;
      if (mem_req_i && !mem_ack_o)
      begin
         if (wait_q == 2'h0)
         begin
            mem_ack_o <= 1'b1;
            wait_q <= 2'($urandom_range(2, 0));
            if (mem_we_i)
               mem[mem_addr_i[12:2]] <= mem_wdata_i;
            else
               rd_q <= mem[mem_addr_i[12:2]];
         end
         else
            wait_q <= wait_q - 2'h1;
      end
   end

   // Read data is only good in the ack cycle
   assign mem_rdata_o = mem_ack_o ? rd_q : ~rd_q;

   // Engine halts the chosen descriptor, noise on halt otherwise
   always @(posedge clk_i)
   begin
      td_done_o <= 1'b0;
      td_halt_o <= 1'($urandom);
      if (td_start_i)
      begin
         busy_q <= 1'b1;
         eng_q <= 3'($urandom_range(4, 0));
      end
      else if (busy_q)
      begin
         if (eng_q == 3'h0)
         begin
            td_done_o <= 1'b1;
            td_halt_o <= (td_addr_i == halt_addr_i);
            busy_q <= 1'b0;
         end
         else
            eng_q <= eng_q - 3'h1;
      end
   end
endmodule : usb_sched_partner

// File: tb_top.sv
`timescale 1ns/1ps

module tb_top;
   localparam int FC = 200;
   logic        clk_i, rst_b_i, run_i, per_enable_i, ctrl_enable_i, bulk_enable_i;
   logic [12:0] ctrl_head_i, bulk_head_i, hcca_base_i, halt_addr, td_addr_o, done_head_o;
   logic        mem_req_o, mem_we_o, mem_ack_i, td_start_o, td_done_i, td_halt_i;
   logic [12:0] mem_addr_o;
   logic [31:0] mem_wdata_o, mem_rdata_i, w_int, w_iso, w_blk, w_ctl;
   logic [6:0]  td_func_addr_o;
   logic [3:0]  td_endpoint_o;
   logic [1:0]  td_dir_o;
   logic        td_low_speed_o, td_iso_o;
   logic [10:0] td_max_packet_o;
   logic [15:0] frame_num_o;
   logic [12:0] got[$];
   int          miscompares, total_checks, n;

   usb_host_list_scheduler #(.FRAME_CYCLES(FC)) i_dut (.clk_i, .rst_b_i, .run_i,
      .per_enable_i, .ctrl_enable_i, .bulk_enable_i, .ctrl_head_i, .bulk_head_i,
      .hcca_base_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i,
      .mem_ack_i, .td_start_o, .td_addr_o, .td_func_addr_o, .td_endpoint_o, .td_dir_o,
      .td_low_speed_o, .td_iso_o, .td_max_packet_o, .td_done_i, .td_halt_i,
      .frame_num_o, .done_head_o);

   usb_sched_partner i_mem (.clk_i(clk_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
      .mem_ack_o(mem_ack_i), .td_start_i(td_start_o), .td_addr_i(td_addr_o),
      .halt_addr_i(halt_addr), .td_done_o(td_done_i), .td_halt_o(td_halt_i));

   always #20 clk_i = ~clk_i;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic results;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   function automatic logic [31:0] ctl(input logic [6:0] fa, input logic [3:0] en,
      input logic [1:0] dir, input logic ls, sk, iso, input logic [10:0] mps);
      return {5'h00, mps, iso, sk, ls, dir, en, fa};
   endfunction : ctl

   function automatic logic [31:0] exp_ctl(input logic [12:0] a);
      if (a == 13'h0400 || a == 13'h0410)
         return w_int;
      return (a == 13'h0480) ? w_iso : w_blk;
   endfunction : exp_ctl

   task automatic ed(input int a, input logic [31:0] c, t, h, nx);
      i_mem.mem[a >> 2] = c;
      i_mem.mem[(a >> 2) + 1] = t;
      i_mem.mem[(a >> 2) + 2] = h;
      i_mem.mem[(a >> 2) + 3] = nx;
   endtask : ed

   // Every start is compared with its endpoint fields
   always @(negedge clk_i)
      if (rst_b_i === 1'b1 && td_start_o === 1'b1)
      begin
         got.push_back(td_addr_o);
         check({td_max_packet_o, td_iso_o, 1'b0, td_low_speed_o, td_dir_o,
            td_endpoint_o, td_func_addr_o}, exp_ctl(td_addr_o), "td fields");
      end

   initial
   begin
      #(60 * FC * 40);
      miscompares++;
      results;
   end

   initial
   begin
      logic [12:0] ord[4];
      logic [12:0] ea[10];
      logic [31:0] ev[10];
      void'($urandom(70));
      clk_i = 1'b0;
      rst_b_i = 1'b0;
      run_i = 1'b0;
      {per_enable_i, ctrl_enable_i, bulk_enable_i} = 3'h0;
      ctrl_head_i = 13'h0200;
      bulk_head_i = 13'h0300;
      hcca_base_i = 13'h1000;
      halt_addr = 13'h0430;
      @(negedge clk_i);
      w_int = ctl(7'h7F, 4'hF, 2'($urandom), 1'b1, 1'b0, 1'b0, 11'($urandom));
      w_iso = ctl(7'($urandom), 4'($urandom), 2'h0, 1'b0, 1'b0, 1'b1, 11'($urandom));
      w_blk = ctl(7'($urandom), 4'($urandom), 2'($urandom), 1'b0, 1'b0, 1'b0, 11'($urandom));
      w_ctl = ctl(7'($urandom), 4'($urandom), 2'h1, 1'b0, 1'b1, 1'b0, 11'($urandom));
      // Interrupt node linked from two slots, iso node after it
      ed('h100, w_int, 'h420, 'h400, 'h140);
      ed('h140, w_iso, 'h490, 'h480, 0);
      ed('h200, w_ctl, 'h470, 'h460, 0);
      ed('h300, w_blk, 'h450, 'h430, 0);
      foreach (ev[i])
         ev[i] = 32'h0;
      i_mem.mem['h1004 >> 2] = 32'h100;
      // Interrupt node polled every 16 frames, a legal period
      i_mem.mem['h1044 >> 2] = 32'h100;
      i_mem.mem['h408 >> 2] = 32'h410;
      i_mem.mem['h418 >> 2] = 32'h420;
      i_mem.mem['h488 >> 2] = 32'h490;
      i_mem.mem['h438 >> 2] = 32'h440;
      i_mem.mem['h448 >> 2] = 32'h450;
      @(negedge clk_i);
      rst_b_i = 1'b1;
      run_i = 1'b1;
      {per_enable_i, ctrl_enable_i, bulk_enable_i} = 3'h7;
      n = 0;
      while (frame_num_o < 16'd35 && n < 40 * FC)
      begin
         @(negedge clk_i);
         n++;
      end
      check(32'(frame_num_o >= 16'd35), 32'h1, "frame count");
      ord = '{13'h0400, 13'h0480, 13'h0430, 13'h0410};
      check(32'(got.size()), 32'h4, "start count");
      for (int i = 0; i < 4 && i < got.size(); i++)
         check(32'(got[i]), 32'(ord[i]), "start order");
      $display("test walk order done");
      ea = '{'h108, 'h148, 'h308, 'h208, 'h408, 'h488, 'h438, 'h418, 'h1084, 'h40C};
      ev[0] = 32'h420;
      ev[1] = 32'h490;
      ev[2] = 32'h441;
      ev[3] = 32'h460;
      ev[5] = 32'h400;
      ev[6] = 32'h480;
      ev[7] = 32'h430;
      ev[8] = 32'h410;
      for (int i = 0; i < 10; i++)
         check(i_mem.mem[ea[i] >> 2], ev[i], "memory word");
      check(32'(done_head_o), 32'h410, "done head");
      $display("test done queue done");
      // Reset in mid-run clears outputs, then the frame counter starts again
      rst_b_i = 1'b0;
      @(negedge clk_i);
      @(negedge clk_i);
      check(32'({frame_num_o, done_head_o, mem_req_o, td_start_o}), 32'h0, "reset outputs");
      rst_b_i = 1'b1;
      bulk_enable_i = 1'b0;
      n = 0;
      while (frame_num_o < 16'd2 && n < 3 * FC)
      begin
         @(negedge clk_i);
         n++;
      end
      check(32'(frame_num_o), 32'h2, "frames after reset");
      check(32'(got.size()), 32'h4, "no start after reset");
      check(i_mem.mem['h1084 >> 2], 32'h410, "done word kept");
      $display("test mid-run reset done");
      results;
   end
endmodule : tb_top
